// *** rtl/pllbw_regs.vh ***
// Register map, field layout and timing constants of the PLL bandwidth and lock control.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register index.
`ifndef PLLBW_REGS_VH
`define PLLBW_REGS_VH

// Register indices, byte address is four times the index
`define PLLBW_IDX_CTL        8'h36
`define PLLBW_IDX_BW         8'h37
`define PLLBW_IDX_MULH       8'h38
`define PLLBW_IDX_MULL       8'h39
`define PLLBW_IDX_RANGE      8'h3A
`define PLLBW_IDX_RDIV       8'h3B
`define PLLBW_IDX_W          8

// Control register fields
`define PLLBW_CTL_IE         7
`define PLLBW_CTL_FLAG       6
`define PLLBW_CTL_PON        5
`define PLLBW_CTL_SEL        4
`define PLLBW_CTL_PRE_HI     3
`define PLLBW_CTL_PRE_LO     2
`define PLLBW_CTL_RPOW_HI    1
`define PLLBW_CTL_RPOW_LO    0

// Bandwidth register fields
`define PLLBW_BW_AUTO        7
`define PLLBW_BW_LOCK        6
`define PLLBW_BW_TRACK       5

// Field widths and reset values
`define PLLBW_MUL_W          12
`define PLLBW_MULH_W         4
`define PLLBW_RANGE_W        8
`define PLLBW_RDIV_W         4
`define PLLBW_RST_MUL        12'h000
`define PLLBW_RST_RANGE      8'h00
`define PLLBW_RST_RDIV       4'h0
`define PLLBW_RST_PON        1'b1

// Bus frequency is the VCO frequency over this power of two
`define PLLBW_BUS_DIV_POW    2'h2

// AXI responses
`define PLLBW_RESP_OKAY      2'h0
`define PLLBW_RESP_SLVERR    2'h2

// Tolerance filter: stable time before a change is accepted
`define PLLBW_FILT_NS        1000
`define PLLBW_CLK_NS         50

`endif

// *** rtl/pllbw_tol_filt.v ***
// Synchroniser and glitch filter for one tolerance level from the analog comparator.
// Assumes the input is asynchronous to aclk; output changes only after a stable run.
module pllbw_tol_filt #(
  parameter CNT_W   = 8,
  parameter [7:0] FILT_CNT = 8'h14
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Level in and filtered level out
  input  wire             lvl_in,
  output reg              lvl_o
);

  reg             sync1_r;
  reg             sync2_r;
  reg [CNT_W-1:0] cnt_r;

  // Second stage alone reads the first; metastability guard
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r   <= {CNT_W{1'b0}};
      lvl_o   <= 1'b0;
    end else begin
      sync1_r <= lvl_in;
      sync2_r <= sync1_r;
      if (sync2_r == lvl_o) begin
        cnt_r <= {CNT_W{1'b0}};
      end else if (cnt_r == FILT_CNT[CNT_W-1:0]) begin
        cnt_r <= {CNT_W{1'b0}};
        lvl_o <= sync2_r;
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pllbw_tol_filt

// *** rtl/pllbw_ctrl.v ***
// PLL bandwidth mode, lock indication and divider programming behind AXI4-Lite.
// Assumes the analog loop reports track and lock tolerance as async levels.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "pllbw_regs.vh"

// Contract
// - Acquisition mode reports indicator clear
// - Tracking whenever indicator set
// - Auto mode: track tolerance detector switches filter mode
// - Auto mode: indicator read-only, writes ignored
// - Auto: indicator follows VCO tolerance
// - Auto: read-only lock bit follows tolerance
// - Auto: lock toggle raises enabled interrupt
// - Manual mode: indicator is writable control
// - Manual: lock bit off, no interrupts
// - VCO = ref*2^P*N/R, bus quarter VCO
// - Zero divider or multiplier acts as one
// - Zero linear factor disables PLL, forces crystal
// - No power-off while selected; no selecting while off
module pllbw_ctrl #(
  parameter ADDR_W  = 10,
  parameter CNT_W   = 8
) (
  // Clock and reset
  input  wire                       aclk,
  input  wire                       aresetn,
  // AXI4-Lite write address
  input  wire                       s_axi_awvalid,
  output reg                        s_axi_awready,
  input  wire [ADDR_W-1:0]          s_axi_awaddr,
  input  wire [2:0]                 s_axi_awprot,
  // AXI4-Lite write data
  input  wire                       s_axi_wvalid,
  output reg                        s_axi_wready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output reg                        s_axi_bvalid,
  input  wire                       s_axi_bready,
  output reg  [1:0]                 s_axi_bresp,
  // AXI4-Lite read address
  input  wire                       s_axi_arvalid,
  output reg                        s_axi_arready,
  input  wire [ADDR_W-1:0]          s_axi_araddr,
  input  wire [2:0]                 s_axi_arprot,
  // AXI4-Lite read data
  output reg                        s_axi_rvalid,
  input  wire                       s_axi_rready,
  output reg  [31:0]                s_axi_rdata,
  output reg  [1:0]                 s_axi_rresp,
  // Analog tolerance levels, asynchronous
  input  wire                       track_tol_in,
  input  wire                       lock_tol_in,
  // Analog loop controls
  output reg                        pll_enable_o,
  output reg                        base_clock_source_select_o,
  output reg                        filter_track_select_o,
  output reg  [1:0]                 prescale_pow_o,
  output reg  [1:0]                 vco_range_power_o,
  output reg  [`PLLBW_RANGE_W-1:0]  range_lin_o,
  output reg  [`PLLBW_MUL_W-1:0]    mul_eff_o,
  output reg  [`PLLBW_RDIV_W-1:0]   ref_div_eff_o,
  output reg  [1:0]                 bus_div_pow_o,
  // Lock change interrupt
  output reg                        lock_irq_o
);

  localparam FILT_CNT_FULL = (`PLLBW_FILT_NS + `PLLBW_CLK_NS - 1) / `PLLBW_CLK_NS;
  localparam [CNT_W-1:0] FILT_CNT = FILT_CNT_FULL[CNT_W-1:0];

  // Control register
  reg                       lock_irq_enable_r;
  reg                       lock_flag_r;
  reg                       pll_power_on_r;
  reg                       base_clock_source_select_r;
  reg [1:0]                 prescale_r;
  reg [1:0]                 vco_range_power_field_r;
  // Bandwidth register
  reg                       auto_r;
  reg                       filter_track_select_r;
  reg                       lock_r;
  // Divider registers
  reg [`PLLBW_MUL_W-1:0]    mul_r;
  reg [`PLLBW_RANGE_W-1:0]  range_lin_r;
  reg [`PLLBW_RDIV_W-1:0]   ref_div_r;
  // Bus slave state
  reg                       aw_have_r;
  reg                       w_have_r;
  reg [`PLLBW_IDX_W-1:0]    aw_idx_r;
  reg [7:0]                 wbyte_r;
  reg                       wlane_r;

  wire                      track_ok;
  wire                      lock_ok;
  wire                      pll_live;
  wire                      wr_go;
  wire                      rd_go;
  wire [`PLLBW_IDX_W-1:0]   ar_idx;
  wire                      wr_ctl;
  wire                      wr_bw;
  wire                      wr_hit;
  wire                      lock_nxt;
  wire                      lock_flag_nxt;
  wire                      pon_req;
  wire                      sel_req;
  wire                      range_zero_nxt;
  reg                       pll_power_on_nxt;
  reg                       base_clock_source_select_nxt;
  reg                       filter_track_select_nxt;
  reg [7:0]                 rbyte_nxt;
  reg                       rhit_nxt;

  // Tolerance detectors, filtered so comparator chatter cannot toggle the lock bit
  pllbw_tol_filt #(
    .CNT_W    (CNT_W),
    .FILT_CNT (FILT_CNT)
  ) u_track_filt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .lvl_in   (track_tol_in),
    .lvl_o    (track_ok)
  );

  pllbw_tol_filt #(
    .CNT_W    (CNT_W),
    .FILT_CNT (FILT_CNT)
  ) u_lock_filt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .lvl_in   (lock_tol_in),
    .lvl_o    (lock_ok)
  );

  // Write decode, byte lane 0 only carries data
  assign wr_go  = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_hit = (aw_idx_r >= `PLLBW_IDX_CTL) && (aw_idx_r <= `PLLBW_IDX_RDIV);
  assign wr_ctl = wr_go & wlane_r & (aw_idx_r == `PLLBW_IDX_CTL);
  assign wr_bw  = wr_go & wlane_r & (aw_idx_r == `PLLBW_IDX_BW);
  assign rd_go  = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[`PLLBW_IDX_W+1:2];

  assign range_zero_nxt = (wr_go & wlane_r & (aw_idx_r == `PLLBW_IDX_RANGE))
                          ? (wbyte_r == `PLLBW_RST_RANGE)
                          : (range_lin_r == `PLLBW_RST_RANGE);
  assign pll_live = pll_power_on_r & (range_lin_r != `PLLBW_RST_RANGE);

  assign pon_req = wbyte_r[`PLLBW_CTL_PON];
  assign sel_req = wbyte_r[`PLLBW_CTL_SEL];

  // Power and base clock interlocks
  always @* begin
    pll_power_on_nxt             = pll_power_on_r;
    base_clock_source_select_nxt = base_clock_source_select_r;
    if (wr_ctl) begin
      if (pon_req | ~base_clock_source_select_r) begin
        pll_power_on_nxt = pon_req;
      end
      // Selection cannot move in the same write as power
      if (pon_req == pll_power_on_r) begin
        if (!sel_req) begin
          base_clock_source_select_nxt = 1'b0;
        end else if (pll_power_on_r && !range_zero_nxt) begin
          base_clock_source_select_nxt = 1'b1;
        end
      end
    end
    if (range_zero_nxt) begin
      base_clock_source_select_nxt = 1'b0;
    end
  end

  // Filter mode: detector driven in auto, software driven in manual
  always @* begin
    filter_track_select_nxt = filter_track_select_r;
    if (auto_r) begin
      filter_track_select_nxt = track_ok & pll_live;
    end else if (wr_bw && !wbyte_r[`PLLBW_BW_AUTO]) begin
      filter_track_select_nxt = wbyte_r[`PLLBW_BW_TRACK];
    end
  end

  // Lock bit exists only in auto mode
  assign lock_nxt = auto_r & pll_live & lock_ok;

  // Flag set wins over a software clear in the same cycle
  assign lock_flag_nxt = (auto_r & (lock_nxt != lock_r)) |
                         (lock_flag_r & ~(wr_ctl & ~wbyte_r[`PLLBW_CTL_FLAG]));

  // Register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_irq_enable_r          <= 1'b0;
      lock_flag_r                <= 1'b0;
      pll_power_on_r             <= `PLLBW_RST_PON;
      base_clock_source_select_r <= 1'b0;
      prescale_r                 <= 2'h0;
      vco_range_power_field_r    <= 2'h0;
      auto_r                     <= 1'b0;
      filter_track_select_r      <= 1'b0;
      lock_r                     <= 1'b0;
      mul_r                      <= `PLLBW_RST_MUL;
      range_lin_r                <= `PLLBW_RST_RANGE;
      ref_div_r                  <= `PLLBW_RST_RDIV;
    end else begin
      pll_power_on_r             <= pll_power_on_nxt;
      base_clock_source_select_r <= base_clock_source_select_nxt;
      filter_track_select_r      <= filter_track_select_nxt;
      lock_r                     <= lock_nxt;
      lock_flag_r                <= lock_flag_nxt;
      if (wr_ctl) begin
        lock_irq_enable_r       <= wbyte_r[`PLLBW_CTL_IE];
        prescale_r              <= wbyte_r[`PLLBW_CTL_PRE_HI:`PLLBW_CTL_PRE_LO];
        vco_range_power_field_r <= wbyte_r[`PLLBW_CTL_RPOW_HI:`PLLBW_CTL_RPOW_LO];
      end
      if (wr_bw) begin
        auto_r <= wbyte_r[`PLLBW_BW_AUTO];
      end
      if (wr_go && wlane_r) begin
        case (aw_idx_r)
          `PLLBW_IDX_MULH: begin
            mul_r[`PLLBW_MUL_W-1:8] <= wbyte_r[`PLLBW_MULH_W-1:0];
          end
          `PLLBW_IDX_MULL: begin
            mul_r[7:0] <= wbyte_r;
          end
          `PLLBW_IDX_RANGE: begin
            range_lin_r <= wbyte_r;
          end
          `PLLBW_IDX_RDIV: begin
            ref_div_r <= wbyte_r[`PLLBW_RDIV_W-1:0];
          end
          default: begin
            mul_r <= mul_r;
          end
        endcase
      end
    end
  end

  // Loop outputs, registered copies of the effective settings
  always @(posedge aclk) begin
    if (!aresetn) begin
      pll_enable_o               <= 1'b0;
      base_clock_source_select_o <= 1'b0;
      filter_track_select_o      <= 1'b0;
      prescale_pow_o             <= 2'h0;
      vco_range_power_o          <= 2'h0;
      range_lin_o                <= `PLLBW_RST_RANGE;
      mul_eff_o                  <= {{(`PLLBW_MUL_W-1){1'b0}}, 1'b1};
      ref_div_eff_o              <= {{(`PLLBW_RDIV_W-1){1'b0}}, 1'b1};
      bus_div_pow_o              <= `PLLBW_BUS_DIV_POW;
      lock_irq_o                 <= 1'b0;
    end else begin
      pll_enable_o               <= pll_live;
      base_clock_source_select_o <= base_clock_source_select_r & pll_live;
      // Clear means acquisition, set means tracking
      filter_track_select_o      <= filter_track_select_r;
      prescale_pow_o             <= prescale_r;
      vco_range_power_o          <= vco_range_power_field_r;
      range_lin_o                <= range_lin_r;
      mul_eff_o                  <= (mul_r == `PLLBW_RST_MUL)
                                    ? {{(`PLLBW_MUL_W-1){1'b0}}, 1'b1} : mul_r;
      ref_div_eff_o              <= (ref_div_r == `PLLBW_RST_RDIV)
                                    ? {{(`PLLBW_RDIV_W-1){1'b0}}, 1'b1} : ref_div_r;
      bus_div_pow_o              <= `PLLBW_BUS_DIV_POW;
      lock_irq_o                 <= lock_flag_r & lock_irq_enable_r & auto_r;
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= {`PLLBW_IDX_W{1'b0}};
      wbyte_r       <= 8'h00;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PLLBW_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[`PLLBW_IDX_W+1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wbyte_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_r     <= 1'b0;
        w_have_r      <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `PLLBW_RESP_OKAY : `PLLBW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
      end
    end
  end

  // Read mux, reserved bits read zero
  always @* begin
    rbyte_nxt = 8'h00;
    rhit_nxt  = 1'b1;
    case (ar_idx)
      `PLLBW_IDX_CTL: begin
        rbyte_nxt = {lock_irq_enable_r, lock_flag_r, pll_power_on_r,
                     base_clock_source_select_r, prescale_r, vco_range_power_field_r};
      end
      `PLLBW_IDX_BW: begin
        rbyte_nxt = {auto_r, lock_r, filter_track_select_r, 5'h00};
      end
      `PLLBW_IDX_MULH: begin
        rbyte_nxt = {4'h0, mul_r[`PLLBW_MUL_W-1:8]};
      end
      `PLLBW_IDX_MULL: begin
        rbyte_nxt = mul_r[7:0];
      end
      `PLLBW_IDX_RANGE: begin
        rbyte_nxt = range_lin_r;
      end
      `PLLBW_IDX_RDIV: begin
        rbyte_nxt = {4'h0, ref_div_r};
      end
      default: begin
        rhit_nxt = 1'b0;
      end
    endcase
  end

  // Read channel: one read outstanding, answered the cycle after acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PLLBW_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rbyte_nxt};
        s_axi_rresp  <= rhit_nxt ? `PLLBW_RESP_OKAY : `PLLBW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pllbw_ctrl

// *** tb/pllbw_ctrl_asserts.sv ***
// Port checker for the PLL bandwidth and lock control.
// Assumes it is bound to pllbw_ctrl and sees only its ports.
`include "pllbw_regs.vh"
module pllbw_ctrl_asserts (
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Register bus
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  // Loop controls
  input wire logic                      pll_enable_o,
  input wire logic                      base_clock_source_select_o,
  input wire logic [`PLLBW_MUL_W-1:0]   mul_eff_o,
  input wire logic [`PLLBW_RDIV_W-1:0]  ref_div_eff_o,
  input wire logic [1:0]                bus_div_pow_o,
  input wire logic                      lock_irq_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_vals: assert property ($rose(aresetn) |-> mul_eff_o == 12'h001 &&
    ref_div_eff_o == 4'h1 && !pll_enable_o && !lock_irq_o) else $error("bad reset outputs");
  chk_mul_nonzero: assert property (mul_eff_o != 12'h000)
    else $error("multiplier zero");
  chk_rdiv_nonzero: assert property (ref_div_eff_o != 4'h0)
    else $error("divider zero");
  chk_bus_quarter: assert property (bus_div_pow_o == 2'h2)
    else $error("bus divider not four");
  chk_sel_needs_en: assert property (base_clock_source_select_o |-> pll_enable_o)
    else $error("vco selected while pll off");
  chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready)
    else $error("read data upper bits set");
endmodule // pllbw_ctrl_asserts

bind pllbw_ctrl pllbw_ctrl_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .pll_enable_o(pll_enable_o),
  .base_clock_source_select_o(base_clock_source_select_o), .mul_eff_o(mul_eff_o),
  .ref_div_eff_o(ref_div_eff_o), .bus_div_pow_o(bus_div_pow_o), .lock_irq_o(lock_irq_o));

// *** tb/pllbw_ctrl_tb_top.sv ***
// Self-checking bench for the PLL bandwidth and lock control.
// Assumes the bench is the only bus master and drives the tolerance levels itself.
`include "pllbw_regs.vh"
module pllbw_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        track_tol_in = 0, lock_tol_in = 0;
  logic        pll_en, sel, track, irq;
  logic [1:0]  pre, rpow, bdiv;
  logic [7:0]  lin;
  logic [11:0] mul;
  logic [3:0]  rdiv;
  int          fail_count = 0, checks_done = 0;

  always #25 aclk = ~aclk;

  pllbw_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .track_tol_in(track_tol_in), .lock_tol_in(lock_tol_in),
    .pll_enable_o(pll_en), .base_clock_source_select_o(sel), .filter_track_select_o(track),
    .prescale_pow_o(pre), .vco_range_power_o(rpow), .range_lin_o(lin), .mul_eff_o(mul),
    .ref_div_eff_o(rdiv), .bus_div_pow_o(bdiv), .lock_irq_o(irq));

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        fail_count++;
        $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task limit(input int n);
    begin
      if (n >= 100) begin
        fail_count++;
        $display("unexpected at %0t: bus wait ran out", $time);
        finish_test;
      end
    end
  endtask

  // Response ready is raised only after valid is seen, so the hold path gets exercised
  task wr(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] exp);
    int n;
    begin
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, data};
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
          r = s_axi_bresp;
          break;
        end
        if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      limit(n);
      chk(r, exp);
      repeat (2) @(posedge aclk);
    end
  endtask

  task rd(input logic [7:0] idx, input logic [31:0] exp);
    int n;
    begin
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= {idx, 2'b00};
      for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          break;
        end
        if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      limit(n);
      chk(d, exp);
    end
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PLLBW_IDX_CTL, 32'h20);
    rd(`PLLBW_IDX_BW, 32'h00);
    chk(mul, 12'h001);
    chk(rdiv, 4'h1);
    chk(bdiv, 2'h2);
    chk(pll_en, 1'b0);
    $display("test reset done");
    wr(`PLLBW_IDX_MULH, 8'h03, 2'h0);
    wr(`PLLBW_IDX_MULL, 8'hD1, 2'h0);
    wr(`PLLBW_IDX_RANGE, 8'hD0, 2'h0);
    wr(`PLLBW_IDX_RDIV, 8'h01, 2'h0);
    wr(`PLLBW_IDX_CTL, 8'h22, 2'h0);
    chk({pre, rpow, lin, mul, rdiv}, {2'h0, 2'h2, 8'hD0, 12'h3D1, 4'h1});
    chk(pll_en, 1'b1);
    wr(`PLLBW_IDX_MULL, 8'h00, 2'h0);
    wr(`PLLBW_IDX_MULH, 8'h00, 2'h0);
    chk(mul, 12'h001);
    wr(8'h10, 8'h55, `PLLBW_RESP_SLVERR);
    rd(8'h10, 32'h00);
    chk(r, `PLLBW_RESP_SLVERR);
    $display("test program done");
    wr(`PLLBW_IDX_CTL, 8'h82, 2'h0);
    chk(pll_en, 1'b0);
    wr(`PLLBW_IDX_BW, 8'h00, 2'h0);
    wr(`PLLBW_IDX_CTL, 8'hA2, 2'h0);
    repeat (40) @(posedge aclk);
    wr(`PLLBW_IDX_BW, 8'h20, 2'h0);
    lock_tol_in <= 1'b1;
    repeat (40) @(posedge aclk);
    chk({irq, track}, 2'b01);
    rd(`PLLBW_IDX_BW, 32'h20);
    wr(`PLLBW_IDX_CTL, 8'hB2, 2'h0);
    chk(sel, 1'b1);
    wr(`PLLBW_IDX_CTL, 8'hA2, 2'h0);
    wr(`PLLBW_IDX_BW, 8'h00, 2'h0);
    chk(track, 1'b0);
    $display("test manual done");
    wr(`PLLBW_IDX_BW, 8'hA0, 2'h0);
    repeat (5) @(posedge aclk);
    chk({irq, track}, 2'b10);
    rd(`PLLBW_IDX_BW, 32'hC0);
    wr(`PLLBW_IDX_CTL, 8'hA2, 2'h0);
    chk(irq, 1'b0);
    lock_tol_in <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(irq, 1'b1);
    rd(`PLLBW_IDX_BW, 32'h80);
    track_tol_in <= 1'b1;
    lock_tol_in <= 1'b1;
    repeat (40) @(posedge aclk);
    chk(track, 1'b1);
    rd(`PLLBW_IDX_BW, 32'hE0);
    track_tol_in <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(track, 1'b0);
    $display("test auto done");
    wr(`PLLBW_IDX_CTL, 8'h32, 2'h0);
    chk(sel, 1'b1);
    wr(`PLLBW_IDX_CTL, 8'h12, 2'h0);
    chk(pll_en, 1'b1);
    rd(`PLLBW_IDX_CTL, 32'h32);
    lock_tol_in <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(`PLLBW_IDX_BW, 32'h80);
    lock_tol_in <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(`PLLBW_IDX_BW, 32'hC0);
    wr(`PLLBW_IDX_RANGE, 8'h00, 2'h0);
    chk({sel, pll_en}, 2'b00);
    wr(`PLLBW_IDX_CTL, 8'h02, 2'h0);
    wr(`PLLBW_IDX_RANGE, 8'hD0, 2'h0);
    wr(`PLLBW_IDX_CTL, 8'h12, 2'h0);
    chk(sel, 1'b0);
    rd(`PLLBW_IDX_CTL, 32'h02);
    $display("test select done");
    finish_test;
  end
endmodule // pllbw_ctrl_tb_top
